// [pkg/pair_transfer_regs.vh]
// Opcode encodings and field positions for the pair-transfer decoder.
// Included by the decoder; definitions only.
`ifndef PAIR_TRANSFER_REGS_VH
`define PAIR_TRANSFER_REGS_VH

`define OP_READ_TIMER1_TO_PAIR      10'h270
`define OP_READ_TIMER2_TO_PAIR      10'h271
`define OP_READ_TIMER3_TO_PAIR      10'h272
`define OP_READ_TIMER4_TO_PAIR      10'h273
`define OP_READ_CONV_RESULT_TO_PAIR 10'h279
`define OP_READ_EXT_REG_TO_PAIR     10'h02A

`define CONVERTER_MODE_SELECT_BIT   3
`define ACC_RESET                   4'h0
`define REG_B_RESET                 4'h0

`endif

// [logic/pair_transfer_instructions.v]
// Decode and execute for the instructions that read an 8-bit source into B:A.
// Assumes the core presents one opcode per instruction-cycle enable, and that
// sources are on clk. Other opcodes change A and B here only through acc_wr and reg_b_wr.
//
// Operation
// - Opcode 270h loads B with timer 1 bits 7..4 and A with bits 3..0, no carry change, no skip.
// - Opcode 271h loads B with timer 2 bits 7..4 and A with bits 3..0, no carry change, no skip.
// - The timer 3 read puts timer 3 bits 7..4 into B and bits 3..0 into A in one cycle.
// - Opcode 273h loads B with timer 4 bits 7..4 and A with bits 3..0, no carry change, no skip.
// - Opcode 279h in conversion mode copies result bits 9..6 into B and bits 5..2 into A.
// - Opcode 279h in comparator mode copies result bits 7..4 into B and bits 3..0 into A.
// - The mode bit is bit 3 of the converter control register.
// - Opcode 02Ah loads B with register E bits 7..4 and A with bits 3..0, no carry change, no skip.
`include "pair_transfer_regs.vh"
`timescale 1ns/1ns
`default_nettype none

module pair_transfer_instructions (
  // Clock and reset
  input  wire        clk,
  input  wire        arst_n,
  // Instruction stream
  input  wire        instr_en,
  input  wire [9:0]  opcode,
  // Sources
  input  wire [7:0]  timer1,
  input  wire [7:0]  timer2,
  input  wire [7:0]  timer3,
  input  wire [7:0]  timer4,
  input  wire [9:0]  conv_result,
  input  wire [3:0]  converter_control_reg,
  input  wire [7:0]  ext_reg,
  // Accumulator and register B writes from other instructions
  input  wire        acc_wr,
  input  wire [3:0]  acc_wdata,
  input  wire        reg_b_wr,
  input  wire [3:0]  reg_b_wdata,
  // Results
  output reg  [3:0]  acc_r,
  output reg  [3:0]  reg_b_r,
  output reg         pair_load_r,
  output reg         skip_r,
  output reg         carry_we_r
);

  // Decode widths
  localparam OP_W  = 10;
  localparam SRC_W = 8;
  localparam NIB_W = 4;

  // Source select codes
  localparam SEL_NONE = 3'h0;
  localparam SEL_TMR1 = 3'h1;
  localparam SEL_TMR2 = 3'h2;
  localparam SEL_TMR3 = 3'h3;
  localparam SEL_TMR4 = 3'h4;
  localparam SEL_CONV = 3'h5;
  localparam SEL_EXT  = 3'h6;

  // Opcode to source select
  function [2:0] source_of;
    input [OP_W-1:0] op;
    begin
      case (op)
        `OP_READ_TIMER1_TO_PAIR:      source_of = SEL_TMR1;
        `OP_READ_TIMER2_TO_PAIR:      source_of = SEL_TMR2;
        `OP_READ_TIMER3_TO_PAIR:      source_of = SEL_TMR3;
        `OP_READ_TIMER4_TO_PAIR:      source_of = SEL_TMR4;
        `OP_READ_CONV_RESULT_TO_PAIR: source_of = SEL_CONV;
        `OP_READ_EXT_REG_TO_PAIR:     source_of = SEL_EXT;
        default:                      source_of = SEL_NONE;
      endcase
    end
  endfunction

  // Any pair-transfer opcode
  function is_pair_op;
    input [OP_W-1:0] op;
    begin
      is_pair_op = (source_of(op) != SEL_NONE);
    end
  endfunction

  wire [2:0]       sel;
  wire             hit;
  wire             take_pair;
  wire             converter_mode_select_bit;
  reg  [SRC_W-1:0] conv_window;
  reg  [SRC_W-1:0] src;
  wire [NIB_W-1:0] src_hi;
  wire [NIB_W-1:0] src_lo;
  reg  [NIB_W-1:0] acc_nxt;
  reg  [NIB_W-1:0] reg_b_nxt;
  genvar           g;

  // Decode of the current word
  assign sel       = source_of(opcode);
  assign hit       = is_pair_op(opcode);
  assign take_pair = instr_en & hit;

  assign converter_mode_select_bit = converter_control_reg[`CONVERTER_MODE_SELECT_BIT];

  // Result window by converter mode
  always @* begin
    if (converter_mode_select_bit) begin
      conv_window = conv_result[7:0];
    end else begin
      conv_window = conv_result[9:2];
    end
  end

  // Source multiplexer
  always @* begin
    src = 8'h00;
    case (sel)
      SEL_TMR1: begin
        src = timer1;
      end
      SEL_TMR2: begin
        src = timer2;
      end
      SEL_TMR3: begin
        src = timer3;
      end
      SEL_TMR4: begin
        src = timer4;
      end
      SEL_CONV: begin
        src = conv_window;
      end
      SEL_EXT: begin
        src = ext_reg;
      end
      default: begin
        src = 8'h00;
      end
    endcase
  end

  // Nibble split, high half to B
  generate
    for (g = 0; g < NIB_W; g = g + 1) begin : g_split
      assign src_hi[g] = src[g + NIB_W];
      assign src_lo[g] = src[g];
    end
  endgenerate

  // Accumulator next value
  always @* begin
    acc_nxt = acc_r;
    if (take_pair) begin
      acc_nxt = src_lo;
    end else if (acc_wr) begin
      acc_nxt = acc_wdata;
    end
  end

  // Register B next value
  always @* begin
    reg_b_nxt = reg_b_r;
    if (take_pair) begin
      reg_b_nxt = src_hi;
    end else if (reg_b_wr) begin
      reg_b_nxt = reg_b_wdata;
    end
  end

  // Accumulator
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_r <= `ACC_RESET;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  // Register B
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_b_r <= `REG_B_RESET;
    end else begin
      reg_b_r <= reg_b_nxt;
    end
  end

  // Executed-transfer pulse
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pair_load_r <= 1'b0;
    end else begin
      pair_load_r <= take_pair;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      skip_r <= 1'b0;
    end else begin
      skip_r <= 1'b0;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      carry_we_r <= 1'b0;
    end else begin
      carry_we_r <= 1'b0;
    end
  end

endmodule // pair_transfer_instructions

`default_nettype wire

// [sim/pair_transfer_props.sv]
// Pair transfer checker; bound to the decoder top, sees its ports.
`timescale 1ns/1ns
`default_nettype none
module pair_transfer_props(input wire logic clk,arst_n,instr_en,skip_r,carry_we_r,pair_load_r,
  input wire logic [9:0] opcode,conv_result,input wire logic [3:0] converter_control_reg,acc_r,reg_b_r,
  input wire logic [7:0] timer1,timer2,timer3,timer4,ext_reg,input wire logic acc_wr,reg_b_wr);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire logic [7:0] pr={reg_b_r,acc_r};
  wire logic [7:0] ts=opcode[1]?(opcode[0]?timer4:timer3):(opcode[0]?timer2:timer1);
  wire logic tm=instr_en&&opcode[9:2]==8'h9C;
  wire logic ad=instr_en&&opcode==10'h279;
  wire logic pe=instr_en&&opcode==10'h02A;
  property p_tm;tm|=>pr==$past(ts);endproperty
  a_tm:assert property(p_tm)else $error("timer");
  property p_cv;ad&&!converter_control_reg[3]|=>pr==$past(conv_result[9:2]);endproperty
  a_cv:assert property(p_cv)else $error("conv");
  property p_cm;ad&&converter_control_reg[3]|=>pr==$past(conv_result[7:0]);endproperty
  a_cm:assert property(p_cm)else $error("comp");
  property p_e;pe|=>pr==$past(ext_reg);endproperty
  a_e:assert property(p_e)else $error("ereg");
  property p_ns;tm|=>!skip_r&&!carry_we_r;endproperty
  a_ns:assert property(p_ns)else $error("flag");
  property p_nf;ad||pe|=>!skip_r&&!carry_we_r&&pair_load_r;endproperty
  a_nf:assert property(p_nf)else $error("flag2");
  property p_hold;!(tm||ad||pe)&&!acc_wr&&!reg_b_wr|=>$stable(pr)&&!pair_load_r;endproperty
  a_hold:assert property(p_hold)else $error("hold");
  c_tm:cover property(tm);
  c_ad:cover property(ad);
  c_pl:cover property(pair_load_r);
endmodule // pair_transfer_props
bind pair_transfer_instructions pair_transfer_props u_props(.*);
`default_nettype wire

// [sim/pair_transfer_instructions_tb.sv]
// Bench for the pair decoder; the checker binds itself.
`timescale 1ns/1ns
`default_nettype none
module pair_transfer_instructions_tb;
  logic clk=0,arst_n=0,instr_en=0,acc_wr=0,reg_b_wr=0,pair_load_r,skip_r,carry_we_r;
  logic [9:0] opcode=0,conv_result=10'h2B6;
  logic [7:0] timer1=8'hA5,timer2=8'h3C,timer3=8'hF0,timer4=8'h1E,ext_reg=8'h69;
  logic [3:0] converter_control_reg=0,acc_wdata=4'hF,reg_b_wdata=4'hF,acc_r,reg_b_r;
  int miscompares=0,total_checks=0;
  always #4 clk=~clk;
  pair_transfer_instructions i_dut(.*);
  task check(input string name,input logic [7:0] seen,input logic [7:0] exp);
    total_checks++;
    if(seen!==exp) begin miscompares++; $display("Error %s exp %h seen %h",name,exp,seen); end
  endtask
  task run(input logic [9:0] o,input logic [3:0] m);
    @(posedge clk) {instr_en,acc_wr,reg_b_wr,opcode,converter_control_reg}<={3'h7,o,m};
    @(posedge clk) {instr_en,acc_wr,reg_b_wr}<=3'h0;
    #1;
    check("flags",{5'h00,pair_load_r,skip_r,carry_we_r},8'h04);
  endtask
  task t_timers;
    run(10'h270,4'h0);
    check("timer1",{reg_b_r,acc_r},timer1);
    run(10'h271,4'h0);
    check("timer2",{reg_b_r,acc_r},timer2);
    run(10'h272,4'h0);
    check("timer3",{reg_b_r,acc_r},timer3);
    run(10'h273,4'h0);
    check("timer4",{reg_b_r,acc_r},timer4);
  endtask
  task t_other;
    run(10'h279,4'h7);
    check("conv",{reg_b_r,acc_r},conv_result[9:2]);
    run(10'h279,4'h8);
    check("comp",{reg_b_r,acc_r},conv_result[7:0]);
    run(10'h02A,4'h0);
    check("ereg",{reg_b_r,acc_r},ext_reg);
  endtask
  task t_refused;
    @(posedge clk) {instr_en,opcode}<={1'b1,10'h000};
    @(posedge clk) instr_en<=1'b0;
    #1;
    check("nonpair",{reg_b_r,acc_r},ext_reg);
    check("load",{7'h00,pair_load_r},8'h00);
    @(posedge clk) {acc_wr,reg_b_wr,acc_wdata,reg_b_wdata}<={2'h3,8'hC3};
    @(posedge clk) {acc_wr,reg_b_wr}<=2'h0;
    #1;
    check("write",{reg_b_r,acc_r},8'h3C);
  endtask
  task complete_run;
    if(miscompares==0&&total_checks>0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat(5) @(posedge clk);
    arst_n<=1;
    t_timers;
    t_other;
    t_refused;
    complete_run;
  end
  initial begin #5000 miscompares++; complete_run; end
endmodule // pair_transfer_instructions_tb
`default_nettype wire
